/* core/fpp_cfg.svh */
// shared constants for the flash protection and program controller
`ifndef FPP_CFG_SVH
`define FPP_CFG_SVH

// ============================================================
// special function register addresses
`define FPP_SFR_CMD 8'hb9
`define FPP_SFR_ADDR_HI 8'hc7
`define FPP_SFR_ADDR_LO 8'hc6
`define FPP_SFR_DATA 8'hbc
`define FPP_SFR_ACCESS_KEY 8'ha1
`define FPP_SFR_PROT_KEY 8'hbb
`define FPP_SFR_READ_PROT 8'hbf
`define FPP_SFR_WP_HI 8'hbe
`define FPP_SFR_WP_LO 8'hbd

// ============================================================
// command codes and keys
`define FPP_CMD_WRITE 8'h01
`define FPP_CMD_ERASE_PAGE 8'h02
`define FPP_CMD_ERASE_ALL 8'h03
`define FPP_CMD_READ 8'h04
`define FPP_CMD_ERASE_WRITE 8'h05
`define FPP_CMD_PROTECT 8'h08
`define FPP_ACCESS_KEY 8'h3b
`define FPP_EMU_LOAD 8'h49
`define FPP_EMU_STORE 8'h46
`define FPP_ERASED 8'hff

// ============================================================
// protection storage locations
`define FPP_LOC_PROT_KEY 14'h3ffa
`define FPP_LOC_READ_PROT 14'h3ffb
`define FPP_LOC_WP0 14'h3ffc
`define FPP_LOC_WP3 14'h3fff
`define FPP_LAST_PAGE 5'h1f
`define FPP_LAST_GROUP 3'h7
`define FPP_PAGE_MSB 13
`define FPP_PAGE_LSB 9
`define FPP_GROUP_LSB 11

// ============================================================
// timing, ns
`define FPP_CLK_NS 8
`define FPP_T_WRITE_NS 30000
`define FPP_T_ERASE_PAGE_NS 20000000
`define FPP_T_ERASE_ALL_NS 200000000
`define FPP_T_ERASE_WRITE_NS 21000000
`define FPP_T_READ_NS 100

`endif

/* core/fpp_pkg.sv */
// types for the flash protection and program controller
package fpp_pkg;
  // sequencer states
  typedef enum logic [1:0] {FPP_IDLE, FPP_BUSY, FPP_COMMIT} fpp_state_t;
  // kind of the running operation
  typedef enum logic [2:0] {FPP_OP_NONE, FPP_OP_WRITE, FPP_OP_EPAGE, FPP_OP_EALL,
                            FPP_OP_READ, FPP_OP_EWRITE, FPP_OP_PROT} fpp_op_t;
endpackage

/* core/fpp_timer.sv */
// down counter timing one flash operation
`timescale 1ns/1ps
module fpp_timer #(
  parameter int W = 26
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic done
);
  // ============================================================
  // counter
  logic [W-1:0] cnt_q; // cycles left
  logic run_q; // counting
  if (W < 2) $error("timer width too small");
  // load on start, pulse done on the last cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= count;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q <= W'(1)) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule // fpp_timer

/* core/fpp_ctrl.sv */
// flash protection and program sequencer with sfr port and download path
`timescale 1ns/1ps
`include "fpp_cfg.svh"
module fpp_ctrl
  import fpp_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int CNT_W = 26,
  parameter int T_WRITE_CYC = (`FPP_T_WRITE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
  parameter int T_EPAGE_CYC = (`FPP_T_ERASE_PAGE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
  parameter int T_EALL_CYC = (`FPP_T_ERASE_ALL_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
  parameter int T_EWRITE_CYC = (`FPP_T_ERASE_WRITE_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS,
  parameter int T_READ_CYC = (`FPP_T_READ_NS + `FPP_CLK_NS - 1) / `FPP_CLK_NS
) (
  input wire logic clk,
  input wire logic nrst,
  // core sfr port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // download host command port
  input wire logic dl_cmd_valid,
  input wire logic [7:0] dl_cmd,
  input wire logic [7:0] dl_data,
  // pin sampled at reset
  input wire logic download_enable_n,
  // flash array
  output logic fl_req,
  output logic [2:0] fl_op,
  output logic [ADDR_W-1:0] fl_addr,
  output logic [7:0] fl_wdata,
  input wire logic [7:0] fl_rdata,
  input wire logic [7:0] prot_image_key,
  input wire logic [7:0] prot_image_read,
  input wire logic [31:0] prot_image_wp,
  output logic [31:0] erase_keep_mask,
  // core control
  output logic core_stall,
  output logic irq_block,
  output logic download_mode,
  output logic cmd_refused
);
  // elaboration checks: decode and timer widths
  if (ADDR_W != `FPP_PAGE_MSB + 1) $error("address width must be 14");
  if (T_EALL_CYC >= (1 << CNT_W)) $error("counter too narrow");

  // ============================================================
  // pin sync and reset capture
  logic dl_s1_q; // first sync stage only
  logic dl_s2_q; // synced pin
  logic boot_q; // capture pending after reset
  logic [1:0] warm_q; // sync chain filled with real pin samples
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dl_s1_q <= 1'b1;
      dl_s2_q <= 1'b1;
      warm_q <= '0;
    end else begin
      dl_s1_q <= download_enable_n;
      dl_s2_q <= dl_s1_q;
      warm_q <= {warm_q[0], 1'b1};
    end
  end
  // mode and protection image latched once after release
  logic [7:0] act_rp_q; // active read protection
  logic [31:0] act_wp_q; // active write protection
  logic [7:0] act_key_q; // active protection key
  logic armed_q; // last page read and write protected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      boot_q <= 1'b1;
      download_mode <= 1'b0;
      act_rp_q <= `FPP_ERASED;
      act_wp_q <= '1;
      act_key_q <= `FPP_ERASED;
      armed_q <= 1'b0;
    end else if (boot_q && warm_q[1]) begin
      // reset values must leave the chain first, else the pin is never seen
      boot_q <= 1'b0;
      download_mode <= !dl_s2_q;
      act_rp_q <= prot_image_read;
      act_wp_q <= prot_image_wp;
      act_key_q <= prot_image_key;
      armed_q <= !prot_image_read[`FPP_LAST_GROUP] && !prot_image_wp[`FPP_LAST_PAGE];
    end
  end

  // zero means protected, gated by the last page
  function automatic logic page_wp(input logic [ADDR_W-1:0] a, input logic [31:0] wp, input logic arm);
    page_wp = arm && !wp[a[`FPP_PAGE_MSB:`FPP_PAGE_LSB]];
  endfunction
  function automatic logic page_rp(input logic [ADDR_W-1:0] a, input logic [7:0] rp, input logic arm);
    page_rp = arm && !rp[a[`FPP_PAGE_MSB:`FPP_GROUP_LSB]];
  endfunction

  // ============================================================
  // staging registers
  logic [7:0] addr_hi_q; // flash_addr_high, also wp pages 24..31
  logic [7:0] addr_lo_q; // flash_addr_low, also wp pages 16..23
  logic [7:0] wp_hi_q; // write_protect_byte_hi
  logic [7:0] wp_lo_q; // write_protect_byte_lo
  logic [7:0] rp_q; // read_protect_reg
  logic [7:0] pkey_q; // protection_key_reg
  logic [7:0] data_q; // flash data register
  logic [7:0] cmd_q; // flash_command_reg
  logic key_ok_q; // access key seen
  logic [7:0] scratch_q; // scratch_register_zero
  fpp_state_t st_q;
  // one write path shared by core and emulator store
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_val;
  logic emu_store;
  assign emu_store = dl_cmd_valid && download_mode && dl_cmd == `FPP_EMU_STORE;
  assign wr_en = (sfr_wr || emu_store) && st_q == FPP_IDLE;
  assign wr_addr = emu_store ? dl_data : sfr_addr;
  assign wr_val = emu_store ? scratch_q : sfr_wdata;

  // emulator load, download mode only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scratch_q <= '0;
    end else if (dl_cmd_valid && download_mode && dl_cmd == `FPP_EMU_LOAD) begin
      scratch_q <= dl_data;
    end
  end

  // sfr writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_hi_q <= '0;
      addr_lo_q <= '0;
      wp_hi_q <= `FPP_ERASED;
      wp_lo_q <= `FPP_ERASED;
      rp_q <= `FPP_ERASED;
      pkey_q <= `FPP_ERASED;
      cmd_q <= '0;
    end else if (wr_en) begin
      unique case (wr_addr)
        `FPP_SFR_ADDR_HI: addr_hi_q <= wr_val;
        `FPP_SFR_ADDR_LO: addr_lo_q <= wr_val;
        `FPP_SFR_WP_HI: wp_hi_q <= wr_val;
        `FPP_SFR_WP_LO: wp_lo_q <= wr_val;
        `FPP_SFR_READ_PROT: rp_q <= wr_val;
        `FPP_SFR_PROT_KEY: pkey_q <= wr_val;
        `FPP_SFR_CMD: cmd_q <= wr_val;
        default: ;
      endcase
    end
  end

  // access key arms one command; consumed by any command write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_ok_q <= 1'b0;
    end else if (wr_en && wr_addr == `FPP_SFR_ACCESS_KEY) begin
      key_ok_q <= wr_val == `FPP_ACCESS_KEY;
    end else if (wr_en && wr_addr == `FPP_SFR_CMD) begin
      key_ok_q <= 1'b0;
    end
  end

  // ============================================================
  // command decode
  logic [ADDR_W-1:0] cur_addr;
  logic is_cmd;
  logic blocked;
  fpp_op_t op_d;
  logic [CNT_W-1:0] cyc_d;
  assign cur_addr = {addr_hi_q[ADDR_W-9:0], addr_lo_q};
  assign is_cmd = wr_en && wr_addr == `FPP_SFR_CMD;
  always_comb begin
    op_d = FPP_OP_NONE;
    cyc_d = '0;
    blocked = !key_ok_q;
    unique case (wr_val)
      `FPP_CMD_WRITE: begin
        op_d = FPP_OP_WRITE;
        cyc_d = CNT_W'(T_WRITE_CYC);
        blocked = blocked || page_wp(cur_addr, act_wp_q, armed_q);
      end
      `FPP_CMD_ERASE_PAGE: begin
        op_d = FPP_OP_EPAGE;
        cyc_d = CNT_W'(T_EPAGE_CYC);
        blocked = blocked || page_wp(cur_addr, act_wp_q, armed_q);
      end
      `FPP_CMD_ERASE_ALL: begin
        op_d = FPP_OP_EALL;
        cyc_d = CNT_W'(T_EALL_CYC);
      end
      `FPP_CMD_READ: begin
        op_d = FPP_OP_READ;
        cyc_d = CNT_W'(T_READ_CYC);
        blocked = blocked || page_rp(cur_addr, act_rp_q, armed_q);
      end
      `FPP_CMD_ERASE_WRITE: begin
        op_d = FPP_OP_EWRITE;
        cyc_d = CNT_W'(T_EWRITE_CYC);
        blocked = blocked || page_wp(cur_addr, act_wp_q, armed_q);
      end
      `FPP_CMD_PROTECT: begin
        op_d = FPP_OP_PROT;
        cyc_d = CNT_W'(T_WRITE_CYC);
        // kernel never programs config bits; key must match once a key is stored
        blocked = blocked || (download_mode && !emu_store)
                  || (act_key_q != `FPP_ERASED && pkey_q != act_key_q);
      end
      default: blocked = 1'b1;
    endcase
  end

  // ============================================================
  // sequencer
  fpp_op_t op_q;
  logic [2:0] prot_idx_q; // protection byte being committed
  logic t_start;
  logic t_done;
  logic go;
  assign go = is_cmd && !blocked;
  assign t_start = go || (st_q == FPP_COMMIT && t_done && prot_idx_q != 3'h5);
  fpp_timer #(.W(CNT_W)) u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(t_start),
    .count(op_q == FPP_OP_PROT && !go ? CNT_W'(T_WRITE_CYC) : cyc_d),
    .done(t_done)
  );
  // state: idle, single op, or six-byte protection commit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= FPP_IDLE;
      op_q <= FPP_OP_NONE;
      prot_idx_q <= '0;
    end else begin
      unique case (st_q)
        FPP_IDLE: begin
          if (go) begin
            op_q <= op_d;
            prot_idx_q <= '0;
            st_q <= op_d == FPP_OP_PROT ? FPP_COMMIT : FPP_BUSY;
          end
        end
        FPP_BUSY: begin
          if (t_done) st_q <= FPP_IDLE;
        end
        FPP_COMMIT: begin
          if (t_done) begin
            if (prot_idx_q == 3'h5) st_q <= FPP_IDLE;
            else prot_idx_q <= prot_idx_q + 3'h1;
          end
        end
      endcase
    end
  end

  // stall and interrupt hold from acceptance to the cycle after done
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_stall <= 1'b0;
      irq_block <= 1'b0;
    end else begin
      core_stall <= go || (st_q != FPP_IDLE && !(t_done && (st_q == FPP_BUSY || prot_idx_q == 3'h5)));
      irq_block <= go || (st_q != FPP_IDLE && !(t_done && (st_q == FPP_BUSY || prot_idx_q == 3'h5)));
    end
  end

  // protection byte selection, key first
  function automatic logic [7:0] prot_byte(input logic [2:0] i, input logic [7:0] k, input logic [7:0] r,
                                           input logic [31:0] w);
    unique case (i)
      3'h0: prot_byte = k;
      3'h1: prot_byte = r;
      3'h2: prot_byte = w[7:0];
      3'h3: prot_byte = w[15:8];
      3'h4: prot_byte = w[23:16];
      default: prot_byte = w[31:24];
    endcase
  endfunction

  // flash array request: one pulse per array operation
  logic [31:0] stage_wp;
  logic [7:0] cur_key;
  logic [7:0] new_key;
  assign stage_wp = {addr_hi_q, addr_lo_q, wp_hi_q, wp_lo_q};
  assign cur_key = prot_byte(prot_idx_q + 3'h1, prot_image_key, prot_image_read, prot_image_wp);
  assign new_key = prot_byte(prot_idx_q + 3'h1, pkey_q, rp_q, stage_wp);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fl_req <= 1'b0;
      fl_op <= '0;
      fl_addr <= '0;
      fl_wdata <= '0;
    end else begin
      fl_req <= go || (st_q == FPP_COMMIT && t_start);
      if (go && op_d != FPP_OP_PROT) begin
        fl_op <= op_d;
        fl_addr <= cur_addr;
        fl_wdata <= data_q;
      end else if (t_start) begin
        fl_op <= FPP_OP_PROT;
        fl_addr <= `FPP_LOC_PROT_KEY + ADDR_W'(go ? 3'h0 : prot_idx_q + 3'h1);
        // and with stored byte: bits only fall, key byte written first
        fl_wdata <= (go ? prot_image_key : cur_key) & (go ? pkey_q : new_key);
      end
    end
  end

  // protected pages kept through whole erase when armed; unarmed, whole erase clears every page
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_keep_mask <= '0;
    end else begin
      erase_keep_mask <= armed_q ? ~act_wp_q : '0;
    end
  end

  // data register: sfr write or read result
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= '0;
    end else if (st_q == FPP_BUSY && t_done && op_q == FPP_OP_READ) begin
      data_q <= fl_rdata;
    end else if (wr_en && wr_addr == `FPP_SFR_DATA) begin
      data_q <= wr_val;
    end
  end

  // refused command flag, one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) cmd_refused <= 1'b0;
    else cmd_refused <= is_cmd && blocked;
  end

  // read mux, registered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= '0;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `FPP_SFR_CMD: sfr_rdata <= cmd_q;
        `FPP_SFR_ADDR_HI: sfr_rdata <= addr_hi_q;
        `FPP_SFR_ADDR_LO: sfr_rdata <= addr_lo_q;
        `FPP_SFR_DATA: sfr_rdata <= data_q;
        `FPP_SFR_WP_HI: sfr_rdata <= wp_hi_q;
        `FPP_SFR_WP_LO: sfr_rdata <= wp_lo_q;
        `FPP_SFR_READ_PROT: sfr_rdata <= rp_q;
        default: sfr_rdata <= '0;
      endcase
    end
  end
endmodule // fpp_ctrl

/* verif/fpp_ctrl_properties.sv */
// port-level checker for the flash protection sequencer
`timescale 1ns/1ps
`include "fpp_cfg.svh"
module fpp_ctrl_props
  import fpp_pkg::*;
#(
  parameter int T_WRITE_CYC = 6,
  parameter int T_EALL_CYC = 20
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic dl_cmd_valid,
  input wire logic [7:0] dl_cmd,
  input wire logic [7:0] dl_data,
  input wire logic download_enable_n,
  input wire logic fl_req,
  input wire logic [2:0] fl_op,
  input wire logic [7:0] prot_image_read,
  input wire logic [31:0] prot_image_wp,
  input wire logic [31:0] erase_keep_mask,
  input wire logic core_stall,
  input wire logic irq_block,
  input wire logic download_mode,
  input wire logic cmd_refused
);
  // ============================================================
  // helper state
  logic key_q; // access key armed
  logic [7:0] scr_q; // mirror of scratch zero
  logic [15:0] cnt_q; // cycles of current stall
  logic [2:0] op_q; // last array op issued
  logic [2:0] up_q; // edges since reset release, saturating
  wire cmd_w = sfr_wr && !core_stall && sfr_addr == `FPP_SFR_CMD;
  wire st_w = dl_cmd_valid && download_mode && !core_stall && dl_cmd == `FPP_EMU_STORE;
  // key is consumed by every command, from either path
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_q <= 1'b0;
    end else if (cmd_w || (st_w && dl_data == `FPP_SFR_CMD)) begin
      key_q <= 1'b0;
    end else if (sfr_wr && !core_stall && sfr_addr == `FPP_SFR_ACCESS_KEY) begin
      key_q <= sfr_wdata == `FPP_ACCESS_KEY;
    end else if (st_w && dl_data == `FPP_SFR_ACCESS_KEY) begin
      key_q <= scr_q == `FPP_ACCESS_KEY;
    end
  end
  // scratch only loads in download mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scr_q <= 8'h00;
    end else if (dl_cmd_valid && download_mode && dl_cmd == `FPP_EMU_LOAD) begin
      scr_q <= dl_data;
    end
  end
  // stall length, op kind and settle counters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 16'h0000;
      op_q <= 3'h0;
      up_q <= 3'h0;
    end else begin
      cnt_q <= core_stall ? cnt_q + 16'h0001 : 16'h0000;
      op_q <= fl_req ? fl_op : op_q;
      up_q <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ============================================================
  // properties
  property p_req_stall; fl_req |-> core_stall; endproperty
  a_req_stall: assert property (p_req_stall) else $error("array request without stall");
  property p_irq; core_stall == irq_block; endproperty
  a_irq: assert property (p_irq) else $error("interrupt block differs from stall");
  property p_nokey; cmd_w && !key_q |=> cmd_refused && !core_stall; endproperty
  a_nokey: assert property (p_nokey) else $error("command without key not refused");
  property p_one; cmd_w && key_q |=> core_stall != cmd_refused; endproperty
  a_one: assert property (p_one) else $error("command neither taken nor refused");
  property p_wr_t; $fell(core_stall) && op_q == FPP_OP_WRITE |-> cnt_q >= T_WRITE_CYC && cnt_q <= T_WRITE_CYC + 3;
  endproperty
  a_wr_t: assert property (p_wr_t) else $error("byte write stall length wrong");
  property p_ea_t; $fell(core_stall) && op_q == FPP_OP_EALL |-> cnt_q >= T_EALL_CYC && cnt_q <= T_EALL_CYC + 3;
  endproperty
  a_ea_t: assert property (p_ea_t) else $error("erase all stall length wrong");
  property p_bound; core_stall |-> cnt_q < 6 * T_WRITE_CYC + T_EALL_CYC + 16; endproperty
  a_bound: assert property (p_bound) else $error("stall too long");
  property p_mode; up_q == 3'h6 |-> download_mode == !download_enable_n; endproperty
  a_mode: assert property (p_mode) else $error("download mode does not follow pin");
  property p_mask; up_q == 3'h6 |-> erase_keep_mask == ((prot_image_wp[31] || prot_image_read[7]) ? 32'h0 :
    ~prot_image_wp); endproperty
  a_mask: assert property (p_mask) else $error("keep mask wrong after reset");
  property p_hold; up_q == 3'h7 |-> $stable(erase_keep_mask) && $stable(download_mode); endproperty
  a_hold: assert property (p_hold) else $error("settings changed without reset");
endmodule // fpp_ctrl_props

bind fpp_ctrl fpp_ctrl_props #(.T_WRITE_CYC(T_WRITE_CYC), .T_EALL_CYC(T_EALL_CYC)) i_fpp_ctrl_props (
  .clk(clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .dl_cmd_valid(dl_cmd_valid), .dl_cmd(dl_cmd), .dl_data(dl_data), .download_enable_n(download_enable_n),
  .fl_req(fl_req), .fl_op(fl_op), .prot_image_read(prot_image_read), .prot_image_wp(prot_image_wp),
  .erase_keep_mask(erase_keep_mask), .core_stall(core_stall), .irq_block(irq_block),
  .download_mode(download_mode), .cmd_refused(cmd_refused));

/* verif/fpp_flash_model.sv */
// behavioural flash array with protection bytes at its top
`timescale 1ns/1ps
module fpp_flash_model (
  input wire logic clk,
  input wire logic fl_req,
  input wire logic [2:0] fl_op,
  input wire logic [13:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic [31:0] erase_keep_mask,
  output logic [7:0] fl_rdata,
  output logic [7:0] prot_image_key,
  output logic [7:0] prot_image_read,
  output logic [31:0] prot_image_wp
);
  // ============================================================
  // storage, non-volatile so never touched by reset
  logic [7:0] mem [0:16383];
  initial begin
    for (int j = 0; j < 16384; j++) begin
      mem[j] = 8'hff; // erased means unprotected
    end
    fl_rdata = 8'h00;
  end
  assign prot_image_key = mem[14'h3ffa];
  assign prot_image_read = mem[14'h3ffb];
  assign prot_image_wp = {mem[14'h3fff], mem[14'h3ffe], mem[14'h3ffd], mem[14'h3ffc]};
  // one operation per request; real cells only clear bits
  always @(posedge clk) begin
    if (fl_req) begin
      case (fl_op)
        3'h1, 3'h6: begin
          mem[fl_addr] <= mem[fl_addr] & fl_wdata;
        end
        3'h2, 3'h5: begin
          for (int j = 0; j < 512; j++) begin
            mem[{fl_addr[13:9], j[8:0]}] <= 8'hff;
          end
          if (fl_op == 3'h5) begin
            mem[fl_addr] <= fl_wdata;
          end
        end
        3'h3: begin
          for (int j = 0; j < 16384; j++) begin
            if (!erase_keep_mask[j[13:9]]) begin
              mem[j] <= 8'hff;
            end
          end
        end
        3'h4: begin
          fl_rdata <= mem[fl_addr];
        end
        default: begin
          fl_rdata <= ~fl_rdata; // stale data must not look valid
        end
      endcase
    end
  end
endmodule // fpp_flash_model

/* verif/flash_protect_program_ctrl_tb.sv */
// self-checking bench for the flash protection sequencer
`timescale 1ns/1ps
`include "fpp_cfg.svh"
module flash_protect_program_ctrl_tb
  import fpp_pkg::*;
;
  // ============================================================
  // signals
  logic clk, nrst, sfr_wr, sfr_rd, dl_cmd_valid, download_enable_n, fl_req;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, dl_cmd, dl_data, fl_wdata, fl_rdata, pk, pr, q, d;
  logic [2:0] fl_op;
  logic [13:0] fl_addr, a;
  logic [31:0] pw, keep, rng;
  logic core_stall, irq_block, download_mode, cmd_refused, ref_seen;
  int bad_count = 0;
  int check_count = 0;
  fpp_ctrl #(.T_WRITE_CYC(6), .T_EPAGE_CYC(12), .T_EALL_CYC(20), .T_EWRITE_CYC(14), .T_READ_CYC(3)) i_fpp_ctrl (
    .clk(clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .dl_cmd_valid(dl_cmd_valid), .dl_cmd(dl_cmd), .dl_data(dl_data),
    .download_enable_n(download_enable_n), .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata(fl_rdata), .prot_image_key(pk), .prot_image_read(pr), .prot_image_wp(pw),
    .erase_keep_mask(keep), .core_stall(core_stall), .irq_block(irq_block), .download_mode(download_mode),
    .cmd_refused(cmd_refused));
  fpp_flash_model i_fpp_flash_model (.clk(clk), .fl_req(fl_req), .fl_op(fl_op), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .erase_keep_mask(keep), .fl_rdata(fl_rdata), .prot_image_key(pk),
    .prot_image_read(pr), .prot_image_wp(pw));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // latch any refusal pulse for the current command
  always @(posedge clk) begin
    if (cmd_refused === 1'b1) ref_seen <= 1'b1;
  end
  // ============================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // pages kept only when the last page is fully protected
  function automatic logic [31:0] exp_mask(input logic [31:0] wp, input logic [7:0] rp);
    return (wp[31] || rp[7]) ? 32'h0 : ~wp;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= ad;
    sfr_wdata <= dt;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  // bounded wait for the stall to drop
  task automatic idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    #1;
    while (core_stall !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 2000) chk(32'h1, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c);
    ref_seen = 1'b0;
    sw(`FPP_SFR_ACCESS_KEY, `FPP_ACCESS_KEY);
    sw(`FPP_SFR_CMD, c);
    idle();
  endtask
  task automatic at(input logic [13:0] ad);
    sw(`FPP_SFR_ADDR_HI, {2'b00, ad[13:8]});
    sw(`FPP_SFR_ADDR_LO, ad[7:0]);
  endtask
  task automatic rd(input logic [13:0] ad, output logic [7:0] v);
    at(ad);
    cmd(`FPP_CMD_READ);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= `FPP_SFR_DATA;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    v = sfr_rdata;
  endtask
  task automatic dp(input logic [7:0] c, input logic [7:0] dt);
    @(posedge clk);
    dl_cmd_valid <= 1'b1;
    dl_cmd <= c;
    dl_data <= dt;
    @(posedge clk);
    dl_cmd_valid <= 1'b0;
  endtask
  // one register write from the host is a load then a store
  task automatic emu(input logic [7:0] ad, input logic [7:0] dt);
    dp(`FPP_EMU_LOAD, dt);
    dp(`FPP_EMU_STORE, ad);
  endtask
  task automatic rst(input logic pin);
    @(posedge clk);
    nrst <= 1'b0;
    download_enable_n <= pin;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("TB: checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog, well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end
  // ============================================================
  // main sequence
  initial begin
    {nrst, sfr_wr, sfr_rd, dl_cmd_valid, ref_seen} = 5'h00;
    {sfr_addr, sfr_wdata, dl_cmd, dl_data} = 32'h0;
    download_enable_n = 1'b1;
    rng = 32'h21;
    rst(1'b1);
    chk(keep, 32'h0);
    chk(download_mode, 32'h0);
    $display("TB: erased state done");
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      a = {i[4:0], rng[8:0]};
      d = rng[23:16];
      at(a);
      sw(`FPP_SFR_DATA, d);
      cmd(`FPP_CMD_WRITE);
      chk(i_fpp_flash_model.mem[a], d);
      sw(`FPP_SFR_DATA, ~d);
      rd(a, q);
      chk(q, d);
    end
    ref_seen = 1'b0;
    sw(`FPP_SFR_CMD, `FPP_CMD_ERASE_ALL);
    idle();
    chk(ref_seen, 32'h1);
    chk(i_fpp_flash_model.mem[a], d);
    $display("TB: random write read done");
    at(14'h3e00);
    sw(`FPP_SFR_DATA, 8'ha5);
    cmd(`FPP_CMD_WRITE);
    sw(`FPP_SFR_ADDR_HI, 8'h7f);
    sw(`FPP_SFR_ADDR_LO, 8'hff);
    sw(`FPP_SFR_WP_HI, 8'hff);
    sw(`FPP_SFR_WP_LO, 8'hff);
    sw(`FPP_SFR_READ_PROT, 8'h7f);
    cmd(`FPP_CMD_PROTECT);
    chk(i_fpp_flash_model.mem[14'h3fff], 8'h7f);
    chk(i_fpp_flash_model.mem[14'h3ffb], 8'h7f);
    chk(keep, 32'h0);
    rst(1'b1);
    chk(keep, exp_mask(32'h7fffffff, 8'h7f));
    at(14'h3e00);
    sw(`FPP_SFR_DATA, 8'h00);
    cmd(`FPP_CMD_WRITE);
    chk(ref_seen, 32'h1);
    cmd(`FPP_CMD_ERASE_ALL);
    chk(i_fpp_flash_model.mem[14'h3e00], 8'ha5);
    chk(i_fpp_flash_model.mem[a], 8'hff);
    rd(14'h3e00, q);
    chk(ref_seen, 32'h1);
    chk(q == 8'ha5, 32'h0);
    $display("TB: protection by code done");
    sw(`FPP_SFR_ADDR_HI, 8'hff);
    sw(`FPP_SFR_ADDR_LO, 8'hff);
    sw(`FPP_SFR_WP_HI, 8'hff);
    sw(`FPP_SFR_WP_LO, 8'hfe);
    sw(`FPP_SFR_READ_PROT, 8'hff);
    cmd(`FPP_CMD_PROTECT);
    chk(i_fpp_flash_model.mem[14'h3fff], 8'h7f);
    chk(i_fpp_flash_model.mem[14'h3ffc], 8'hfe);
    $display("TB: add-only protection done");
    rst(1'b0);
    chk(download_mode, 32'h1);
    emu(`FPP_SFR_ADDR_HI, 8'h3c);
    emu(`FPP_SFR_ADDR_LO, 8'h00);
    emu(`FPP_SFR_DATA, 8'h5a);
    emu(`FPP_SFR_ACCESS_KEY, `FPP_ACCESS_KEY);
    emu(`FPP_SFR_CMD, `FPP_CMD_WRITE);
    idle();
    chk(i_fpp_flash_model.mem[14'h3c00], 8'h5a);
    ref_seen = 1'b0;
    emu(`FPP_SFR_ADDR_HI, 8'h3e);
    emu(`FPP_SFR_ADDR_LO, 8'h01);
    emu(`FPP_SFR_DATA, 8'h00);
    emu(`FPP_SFR_ACCESS_KEY, `FPP_ACCESS_KEY);
    emu(`FPP_SFR_CMD, `FPP_CMD_WRITE);
    idle();
    chk(ref_seen, 32'h1);
    chk(i_fpp_flash_model.mem[14'h3e01], 8'hff);
    $display("TB: download path done");
    summarize();
  end
endmodule // flash_protect_program_ctrl_tb
